// File: design/lvds_ser_pkg.sv
// Constants and types for the receive LVDS output serializer
package lvds_ser_pkg;
  localparam int WORD_W = 12;
  localparam int HALF_W = 6;
  localparam int PHASES = 12;
  localparam logic [3:0] LAST_PHASE = 4'hB;
  localparam logic [3:0] HALF_PHASE = 4'h6;
  localparam int FIFO_W = 24;
  localparam int FIFO_DEPTH = 32;
  // Link clock and system clock periods in ns
  localparam int LINK_PERIOD_NS = 48;
  localparam int CLK_PERIOD_NS = 4;
  localparam int PHASE_CYC_RAW = LINK_PERIOD_NS / (PHASES * CLK_PERIOD_NS);
  localparam int PHASE_CYCLES = (PHASE_CYC_RAW < 1) ? 1 : PHASE_CYC_RAW;
  localparam logic [7:0] TICK_LAST = 8'(PHASE_CYCLES - 1);
  localparam logic [7:0] TICK_RESET = 8'h00;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_DUAL_DDR = 2'h1,
    MODE_DUAL_SDR = 2'h2
  } lane_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1
  } ser_state_t;
endpackage : lvds_ser_pkg

// File: design/stream_fifo.sv
// Sample word FIFO with registered read data
`timescale 1ns/1ns
module stream_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop_mem;
  logic [AW:0] level;
  logic [AW:0] next_level;
  logic pop_out;

  // Handshakes on both sides
  assign push = in_valid && in_ready;
  assign pop_mem = (count != '0) && (!out_valid || out_ready);
  assign pop_out = out_valid && out_ready;

  always_comb
  begin
    next_count = count;
    if (push && !pop_mem)
      next_count = count + 1'b1;
    else if (!push && pop_mem)
      next_count = count - 1'b1;
  end

  // Total occupancy, output register included
  always_comb
  begin
    next_level = level;
    if (push && !pop_out)
      next_level = level + 1'b1;
    else if (!push && pop_out)
      next_level = level - 1'b1;
  end

  // Storage write
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // Pointers, fill level and ready
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      level <= '0;
      in_ready <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop_mem)
        rd_ptr <= rd_ptr + 1'b1;
      count <= next_count;
      level <= next_level;
      // Full at DEPTH words, so the output stage is no extra slot
      in_ready <= (next_level < (AW+1)'(DEPTH));
    end
  end

  // Registered output stage
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (pop_mem)
    begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end
    else if (out_ready)
      out_valid <= 1'b0;
  end

  a_no_overfill: assert property (@(posedge clk) disable iff (srst)
    count <= (AW+1)'(DEPTH))
    else $error("fifo fill level above depth");
endmodule : stream_fifo

// File: design/rx_lvds_serializer.sv
// Receive converter words serialized onto LVDS data, bit and frame clocks
`timescale 1ns/1ns
module rx_lvds_serializer
  import lvds_ser_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic rx_path_override_enable,
  input wire logic [1:0] lane_mode,
  input wire logic adc_sample_clock,
  input wire logic [WORD_W-1:0] sample_a,
  input wire logic [WORD_W-1:0] sample_b,
  input wire logic sample_valid,
  output logic sample_ready,
  output logic rx_word_frame_clock_out,
  output logic rx_serial_bit_clock_out,
  output logic [1:0] rx_converter_a_out,
  output logic [1:0] rx_converter_b_out,
  output logic underrun
);
  logic link_meta;
  logic link_sync;
  logic link_prev;
  logic link_rise;
  logic enable_meta;
  logic enable_sync;
  logic [7:0] tick_cnt;
  logic tick;
  logic [3:0] phase;
  ser_state_t state;
  ser_state_t next_state;
  lane_mode_t mode_r;
  lane_mode_t mode_in;
  logic [WORD_W-1:0] word_a;
  logic [WORD_W-1:0] word_b;
  logic frame_half;
  logic load;
  logic running;
  logic fifo_valid;
  logic [FIFO_W-1:0] fifo_data;
  logic [3:0] idx_hi;
  logic [3:0] idx_lo;
  logic next_bitclk;
  logic next_frame;

  // Sample words buffered from the converter core
  stream_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data({sample_a, sample_b}),
    .out_valid(fifo_valid),
    .out_ready(load),
    .out_data(fifo_data)
  );

  // Two-stage synchronisers for the pin-side inputs
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      link_meta <= 1'b0;
      link_sync <= 1'b0;
      link_prev <= 1'b0;
      enable_meta <= 1'b0;
      enable_sync <= 1'b0;
    end
    else
    begin
      link_meta <= adc_sample_clock;
      link_sync <= link_meta;
      link_prev <= link_sync;
      enable_meta <= rx_path_override_enable;
      enable_sync <= enable_meta;
    end
  end

  assign link_rise = link_sync && !link_prev;

  // Phase step enable divider
  always_ff @(posedge clk)
  begin
    if (srst || load)
      tick_cnt <= TICK_RESET;
    else if (tick_cnt == TICK_LAST)
      tick_cnt <= TICK_RESET;
    else
      tick_cnt <= tick_cnt + 8'h01;
  end

  assign tick = (tick_cnt == TICK_LAST);

  // Run control: serializer idles without the override bit
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (enable_sync && link_rise)
          next_state = ST_RUN;
      ST_RUN:
        if (!enable_sync)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  assign running = (state == ST_RUN);
  // Each rising sampling clock edge starts a new word period while the override bit is set
  assign load = link_rise && enable_sync;

  always_comb
  begin
    case (lane_mode)
      2'h1: mode_in = MODE_DUAL_DDR;
      2'h2: mode_in = MODE_DUAL_SDR;
      default: mode_in = MODE_SINGLE;
    endcase
  end

  // Phase counter, realigned on each word boundary
  always_ff @(posedge clk)
  begin
    if (srst)
      phase <= 4'h0;
    else if (load)
      phase <= 4'h0;
    else if (tick && phase != LAST_PHASE)
      phase <= phase + 4'h1;
  end

  // Word capture at the boundary; zero word on underrun
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      word_a <= '0;
      word_b <= '0;
      mode_r <= MODE_SINGLE;
      frame_half <= 1'b0;
      underrun <= 1'b0;
    end
    else
    begin
      underrun <= load && !fifo_valid;
      if (load)
      begin
        word_a <= fifo_valid ? fifo_data[FIFO_W-1:WORD_W] : '0;
        word_b <= fifo_valid ? fifo_data[WORD_W-1:0] : '0;
        mode_r <= mode_in;
        frame_half <= running ? !frame_half : 1'b1;
      end
    end
  end

  // Bit selection per mode: MSB first, upper half on pair zero
  always_comb
  begin
    if (mode_r == MODE_SINGLE)
    begin
      idx_hi = LAST_PHASE - phase;
      idx_lo = 4'h0;
    end
    else
    begin
      idx_hi = LAST_PHASE - {1'b0, phase[3:1]};
      idx_lo = 4'(HALF_W - 1) - {1'b0, phase[3:1]};
    end
  end

  // Bit and frame clock shapes per mode
  always_comb
  begin
    case (mode_r)
      MODE_DUAL_DDR:
      begin
        next_bitclk = !phase[1];
        next_frame = frame_half;
      end
      MODE_DUAL_SDR:
      begin
        next_bitclk = !phase[0];
        next_frame = (phase < HALF_PHASE);
      end
      default:
      begin
        next_bitclk = !phase[0];
        next_frame = (phase < HALF_PHASE);
      end
    endcase
  end

  // Registered pin drivers, quiet while idle
  always_ff @(posedge clk)
  begin
    if (srst || !running)
    begin
      rx_serial_bit_clock_out <= 1'b0;
      rx_word_frame_clock_out <= 1'b0;
      rx_converter_a_out <= 2'h0;
      rx_converter_b_out <= 2'h0;
    end
    else
    begin
      rx_serial_bit_clock_out <= next_bitclk;
      rx_word_frame_clock_out <= next_frame;
      rx_converter_a_out[0] <= word_a[idx_hi];
      rx_converter_b_out[0] <= word_b[idx_hi];
      // Second pair used only in the dual modes
      if (mode_r == MODE_SINGLE)
      begin
        rx_converter_a_out[1] <= 1'b0;
        rx_converter_b_out[1] <= 1'b0;
      end
      else
      begin
        rx_converter_a_out[1] <= word_a[idx_lo];
        rx_converter_b_out[1] <= word_b[idx_lo];
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_phase_range: assert property (phase <= LAST_PHASE)
    else $error("phase past last slot");

  a_msb_first: assert property (
    (running && $past(running) && phase == 4'h0 && $past(load))
      |=> (rx_converter_a_out[0] == $past(word_a[WORD_W-1])))
    else $error("first bit is not the MSB");

  a_single_toggle: assert property (
    (running && mode_r == MODE_SINGLE && phase != LAST_PHASE && !load
      && enable_sync && $past(running))
      |=> ##1 (rx_serial_bit_clock_out != $past(rx_serial_bit_clock_out)))
    else $error("single pair bit clock missed a toggle");

  a_frame_boundary: assert property (
    (running && mode_r != MODE_DUAL_DDR && phase == 4'h0)
      |=> rx_word_frame_clock_out)
    else $error("frame clock low at word start");

  a_half_rate: assert property (
    (running && load && mode_in == MODE_DUAL_DDR)
      |=> ##1 (rx_word_frame_clock_out == !$past(frame_half, 2)))
    else $error("dual ddr frame did not toggle per word");

  a_ddr_slow_clk: assert property (
    (running && mode_r == MODE_DUAL_DDR && !load && phase[0])
      |=> (rx_serial_bit_clock_out == $past(rx_serial_bit_clock_out)))
    else $error("dual ddr bit clock too fast");

  a_split_pairs: assert property (
    (running && mode_r != MODE_SINGLE && phase == 4'h0 && !load)
      |=> (rx_converter_a_out[1] == $past(word_a[HALF_W-1])))
    else $error("second pair does not start at bit five");

  a_sdr_rising: assert property (
    (running && $past(running) && mode_r == MODE_DUAL_SDR
      && $past(mode_r) == MODE_DUAL_SDR
      && $changed(rx_converter_a_out))
      |-> (rx_serial_bit_clock_out && !$past(rx_serial_bit_clock_out)))
    else $error("sdr data changed off a rising edge");

  a_idle_quiet: assert property (
    (!enable_sync) |=> ##1 (!rx_serial_bit_clock_out
      && rx_converter_a_out == 2'h0))
    else $error("outputs active without override bit");

  // First word frame, SDR frame, spare pair and underrun word
  a_first_frame: assert property (
    (load && !running && mode_in == MODE_DUAL_DDR)
      |=> ##1 rx_word_frame_clock_out)
    else $error("first dual ddr word has no frame edge");

  a_sdr_frame: assert property (
    (running && mode_r == MODE_DUAL_SDR && phase == HALF_PHASE)
      |=> !rx_word_frame_clock_out)
    else $error("sdr frame not low in second half");

  a_spare_pair: assert property (
    (running && mode_r == MODE_SINGLE)
      |=> (rx_converter_a_out[1] == 1'b0 && rx_converter_b_out[1] == 1'b0))
    else $error("second pair active in single mode");

  a_underrun_word: assert property (
    (load && !fifo_valid)
      |=> (underrun && word_a == '0 && word_b == '0))
    else $error("underrun did not send a zero word");
endmodule : rx_lvds_serializer

// File: verification/lvds_rx_deser.sv
// Receiving deserializer model for the serialized sample link
`timescale 1ns/1ns
module lvds_rx_deser (
  input wire logic clk,
  input wire logic [1:0] mode,
  input wire logic frame,
  input wire logic bclk,
  input wire logic [1:0] pa,
  input wire logic [1:0] pb,
  output logic got,
  output logic [11:0] wa,
  output logic [11:0] wb,
  output int edges,
  output int bad
);
  int ph = 12;
  logic fq = 1'h0;
  logic bq = 1'h0;
  logic [3:0] dq = 4'h0;
  wire ddr = (mode == 2'h1);
  wire dual = ddr || (mode == 2'h2);
  // Samples settled pins mid-cycle, one phase per cycle
  always @(negedge clk)
  begin
    got <= 1'h0;
    if (frame != fq && (ddr || frame))
      ph = 0;
    else if (ph < 12)
      ph = ph + 1;
    if (ph < 12)
    begin
      if (ph == 0)
        edges = 0;
      if (bclk && !bq)
        edges = edges + 1;
      if ({pa, pb} != dq && (bclk == bq || (mode == 2'h2 && !bclk)))
        bad = bad + 1;
      if (!dual)
      begin
        wa[11 - ph] = pa[0];
        wb[11 - ph] = pb[0];
      end
      else if (ph % 2 == 0)
      begin
        wa[11 - ph / 2] = pa[0];
        wa[5 - ph / 2] = pa[1];
        wb[11 - ph / 2] = pb[0];
        wb[5 - ph / 2] = pb[1];
      end
      if (ph == 11)
        got <= 1'h1;
    end
    fq = frame;
    bq = bclk;
    dq = {pa, pb};
  end
endmodule : lvds_rx_deser

// File: verification/test_adc_lvds_output_serializer.sv
// Testbench for the receive LVDS output serializer
`timescale 1ns/1ns
module test_adc_lvds_output_serializer;
  import lvds_ser_pkg::*;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic ovr = 1'h0;
  logic sclk = 1'h0;
  logic sv = 1'h0;
  logic [1:0] mode = 2'h0;
  logic [11:0] sa = 12'h000;
  logic [11:0] sb = 12'h000;
  logic rdy, fr, bc, und, got;
  logic [1:0] pa, pb;
  logic [11:0] wa, wb;
  logic [31:0] seed = 32'h00010955;
  logic [23:0] exq[$];
  logic [23:0] w;
  int edges, bad;
  int err_total = 0;
  int check_count = 0;
  int credit = 0;
  int cyc = 0;

  initial forever #2 clk = ~clk;
  // Sampling clock, phase unrelated to clk
  initial
  begin
    #7;
    forever #24 sclk = ~sclk;
  end

  rx_lvds_serializer DUT (.clk(clk), .srst(srst),
    .rx_path_override_enable(ovr), .lane_mode(mode),
    .adc_sample_clock(sclk), .sample_a(sa), .sample_b(sb),
    .sample_valid(sv), .sample_ready(rdy),
    .rx_word_frame_clock_out(fr), .rx_serial_bit_clock_out(bc),
    .rx_converter_a_out(pa), .rx_converter_b_out(pb), .underrun(und));

  lvds_rx_deser far (.clk(clk), .mode(mode), .frame(fr), .bclk(bc),
    .pa(pa), .pb(pb), .got(got), .wa(wa), .wb(wb), .edges(edges),
    .bad(bad));

  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic close_out();
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Offers one random word, held until taken
  task automatic push();
    seed = lfsr(seed);
    {sa, sb} = seed[23:0];
    sv = 1'h1;
    while (rdy !== 1'h1)
      @(negedge clk);
    exq.push_back(seed[23:0]);
    @(negedge clk);
  endtask : push

  // Underrun credits and hang limit
  always @(negedge clk)
  begin
    if (und === 1'h1)
      credit++;
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      close_out();
    end
  end

  // Reference comparison at every received word that is not a credited underrun zero word
  always @(posedge clk)
    if (got === 1'h1)
    begin
      if (credit > 0 && {wa, wb} === 24'h0 &&
          (exq.size() == 0 || exq[0] !== 24'h0))
        credit--;
      else
      begin
        w = (exq.size() > 0) ? exq.pop_front() : 24'hFFFFFF;
        check("word", {wa, wb}, w);
        check("bit clock rises", edges, (mode == 2'h1) ? 3 : 6);
        check("off edge changes", bad, 0);
      end
    end

  // Main sequence
  initial
  begin
    repeat (16) @(negedge clk);
    srst = 1'h0;
    repeat (40) @(negedge clk);
    check("idle pins", {fr, bc, pa, pb}, 0);
    check("ready", rdy, 1);
    repeat (FIFO_DEPTH) push();
    {sa, sb} = 24'hABCDEF;
    repeat (4) @(negedge clk);
    check("full", rdy, 0);
    sv = 1'h0;
    for (int m = 0; m < 4; m++)
    begin
      mode = 2'(m);
      ovr = 1'h1;
      repeat (8) push();
      sv = 1'h0;
      while (exq.size() != 0)
        @(negedge clk);
      repeat (30) @(negedge clk);
      ovr = 1'h0;
      repeat (30) @(negedge clk);
      check("stopped pins", {fr, bc, pa, pb}, 0);
      check("underruns", credit, 0);
    end
    close_out();
  end
endmodule : test_adc_lvds_output_serializer
